/* File: rtl/fcwc_host.sv */
// Host-side controller driving the flash strobes, address and data pins.
// Assumes the device is a plain asynchronous byte-wide flash; the elevated
// reset voltage is produced off chip from the hv_reset_en_o request.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Elevated reset pin enters temporary unprotect mode.
// - Host writes with chip, write low, output high.
// - Host resets after timeout flag or identification; the code writes RESET_CMD only on an FCWC_OP_RESET request.
// - Two unlocks plus identification command enter mode.
module fcwc_host
  import fcwc_pkg::*;
#(
  parameter logic [20:0] UNLOCK1_ADDR = UNLOCK1_ADDR_DEFAULT,
  parameter logic [7:0] UNLOCK1_DATA = UNLOCK1_DATA_DEFAULT,
  parameter logic [20:0] UNLOCK2_ADDR = UNLOCK2_ADDR_DEFAULT,
  parameter logic [7:0] UNLOCK2_DATA = UNLOCK2_DATA_DEFAULT,
  parameter logic [7:0] RESET_CMD = RESET_CMD_DEFAULT,
  parameter logic [7:0] ID_CMD = ID_CMD_DEFAULT
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input wire fcwc_req_type req_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  output logic ident_mode_o,
  output logic timeout_seen_o,
  input wire logic unprotect_req_i,
  output logic hv_reset_en_o,
  output fcwc_strobe_type strobe_o,
  output logic [20:0] addr_o,
  output logic [7:0] data_o,
  output logic data_oe_o,
  input wire logic [7:0] data_i
);
  // The phase counter is four bits wide, so longer phases cannot be served.
  if (SETUP_CYC < 1 || PULSE_CYC < 1 || SETUP_CYC > 15 || PULSE_CYC + SYNC_CYC > 15)
  begin : g_bad_timing
    $error("fcwc_host: timing counts out of range.");
  end

  typedef enum logic [2:0] {
    FCWC_IDLE,
    FCWC_SETUP,
    FCWC_PULSE,
    FCWC_HOLD
  } fcwc_state_type;

  typedef enum logic [2:0] {
    SEQ_NONE,
    SEQ_U1,
    SEQ_U2,
    SEQ_CMD
  } fcwc_seq_type;

  fcwc_state_type state;
  fcwc_state_type next_state;
  fcwc_seq_type seq;
  fcwc_seq_type next_seq;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  fcwc_req_type cur;
  fcwc_req_type next_cur;
  fcwc_strobe_type strobe;
  fcwc_strobe_type next_strobe;
  logic [20:0] addr;
  logic [20:0] next_addr;
  logic [7:0] wdata;
  logic [7:0] next_wdata;
  logic oe;
  logic next_oe;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  logic rvalid;
  logic next_rvalid;
  logic ident;
  logic next_ident;
  logic tmo;
  logic next_tmo;
  logic hv;
  logic next_hv;
  logic [7:0] data_s;

  fcwc_sync #(
    .WIDTH(DATA_W)
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .clk_en_i(clk_en_i),
    .async_i(data_i),
    .sync_o(data_s)
  );

  function automatic logic is_write(input fcwc_op_type op);
    is_write = (op != FCWC_OP_READ);
  endfunction : is_write

  assign req_ready_o = (state == FCWC_IDLE) && (seq == SEQ_NONE);

  always_comb
  begin
    next_state = state;
    next_seq = seq;
    next_cnt = cnt;
    next_cur = cur;
    next_strobe = strobe;
    next_addr = addr;
    next_wdata = wdata;
    next_oe = oe;
    next_rdata = rdata;
    next_rvalid = 1'b0;
    next_ident = ident;
    next_tmo = tmo;
    next_hv = unprotect_req_i;
    case (state)
      FCWC_IDLE:
      begin
        if (seq == SEQ_U1 || seq == SEQ_U2 || seq == SEQ_CMD)
        begin
          // Unlocks and identification command are written from UNLOCK1_ADDR, UNLOCK2_ADDR and ID_CMD, not the stored request.
          next_state = FCWC_SETUP;
          next_cnt = SETUP_CNT;
          next_oe = 1'b1;
          next_addr = (seq == SEQ_U1) ? UNLOCK1_ADDR :
                      (seq == SEQ_U2) ? UNLOCK2_ADDR : UNLOCK1_ADDR;
          next_wdata = (seq == SEQ_U1) ? UNLOCK1_DATA :
                       (seq == SEQ_U2) ? UNLOCK2_DATA : ID_CMD;
        end
        else if (req_valid_i)
        begin
          next_cur = req_i;
          next_state = FCWC_SETUP;
          next_cnt = SETUP_CNT;
          next_addr = req_i.addr;
          next_wdata = req_i.data;
          next_oe = is_write(req_i.op);
          if (req_i.op == FCWC_OP_RESET)
          begin
            next_wdata = RESET_CMD;
          end
          else if (req_i.op == FCWC_OP_IDENT)
          begin
            next_seq = SEQ_U1;
            next_state = FCWC_IDLE;
            next_oe = 1'b0;
          end
        end
      end
      FCWC_SETUP:
      begin
        // Output enable is parked high for writes and unlock steps, and driven low for reads, before chip enable falls.
        next_strobe.out_en_n = is_write(cur.op) || seq != SEQ_NONE;
        if (cnt == CNT_ONE)
        begin
          next_state = FCWC_PULSE;
          next_cnt = PULSE_CNT;
          next_strobe.chip_en_n = 1'b0;
          if (next_strobe.out_en_n)
          begin
            next_strobe.write_en_n = 1'b0;
          end
          else
          begin
            // Reads stay low long enough for the byte to cross the pin synchroniser.
            next_strobe.write_en_n = 1'b1;
            next_cnt = READ_PULSE_CNT;
          end
        end
        else
        begin
          next_cnt = cnt - CNT_ONE;
        end
      end
      FCWC_PULSE:
      begin
        if (cnt == CNT_ONE)
        begin
          // Both strobes rise together; the data stays driven through the hold phase.
          next_state = FCWC_HOLD;
          next_cnt = SETUP_CNT;
          next_strobe.write_en_n = 1'b1;
          next_strobe.chip_en_n = 1'b1;
          if (!strobe.out_en_n)
          begin
            // The flag is only meaningful on a byte the device is really driving.
            next_rdata = data_s;
            next_tmo = tmo | (data_s[TLE_BIT] & ~ident);
          end
        end
        else
        begin
          next_cnt = cnt - CNT_ONE;
        end
      end
      FCWC_HOLD:
      begin
        if (cnt == CNT_ONE)
        begin
          next_state = FCWC_IDLE;
          next_oe = 1'b0;
          next_strobe.out_en_n = 1'b1;
          if (seq == SEQ_U1)
          begin
            next_seq = SEQ_U2;
          end
          else if (seq == SEQ_U2)
          begin
            next_seq = SEQ_CMD;
          end
          else if (seq == SEQ_CMD)
          begin
            next_seq = SEQ_NONE;
            next_ident = 1'b1;
          end
          else if (cur.op == FCWC_OP_READ)
          begin
            next_rvalid = 1'b1;
          end
          else if (cur.op == FCWC_OP_RESET)
          begin
            next_ident = 1'b0;
            next_tmo = 1'b0;
          end
        end
        else
        begin
          next_cnt = cnt - CNT_ONE;
        end
      end
      default:
      begin
        next_state = FCWC_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state <= FCWC_IDLE;
      seq <= SEQ_NONE;
      cnt <= CNT_ZERO;
      cur <= '0;
      strobe <= '1;
      addr <= '0;
      wdata <= '0;
      oe <= 1'b0;
      rdata <= '0;
      rvalid <= 1'b0;
      ident <= 1'b0;
      tmo <= 1'b0;
      hv <= 1'b0;
    end
    else if (clk_en_i)
    begin
      state <= next_state;
      seq <= next_seq;
      cnt <= next_cnt;
      cur <= next_cur;
      strobe <= next_strobe;
      addr <= next_addr;
      wdata <= next_wdata;
      oe <= next_oe;
      rdata <= next_rdata;
      rvalid <= next_rvalid;
      ident <= next_ident;
      tmo <= next_tmo;
      hv <= next_hv;
    end
  end

  assign strobe_o = strobe;
  assign addr_o = addr;
  assign data_o = wdata;
  assign data_oe_o = oe;
  assign rd_data_o = rdata;
  assign rd_valid_o = rvalid;
  assign ident_mode_o = ident;
  assign timeout_seen_o = tmo;
  assign hv_reset_en_o = hv;

  write_strobes_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (!strobe.write_en_n) |-> (!strobe.chip_en_n && strobe.out_en_n && oe))
    else $error("Write strobe without legal companion strobes.");
  addr_stable_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (!strobe.chip_en_n && $past(!strobe.chip_en_n)) |-> $stable(addr))
    else $error("Address moved during a strobe.");
  data_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ($rose(strobe.write_en_n) && clk_en_i) |-> (oe && $stable(wdata)))
    else $error("Data not held at write enable rise.");
  bus_turn_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (!strobe.out_en_n) |-> (!oe && strobe.write_en_n))
    else $error("Output enable active while the host drives data.");
  ident_entry_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $rose(ident) |-> $past(seq) == SEQ_CMD)
    else $error("Identification entered without its sequence.");
endmodule : fcwc_host
`default_nettype wire

/* File: rtl/fcwc_pkg.sv */
// Package for the flash command and write-control host controller.
// Assumes a 20 MHz reference clock and a byte-wide asynchronous flash device.
package fcwc_pkg;
  localparam int ADDR_W = 21;
  localparam int DATA_W = 8;
  localparam int GROUP_MSB = 20;
  localparam int GROUP_LSB = 18;
  localparam logic [7:0] ID_MFR_LOW = 8'h00;
  localparam logic [7:0] ID_DEV_LOW = 8'h01;
  localparam logic [7:0] ID_PROT_LOW = 8'h02;
  localparam logic [7:0] PROT_YES = 8'h01;
  localparam logic [7:0] PROT_NO = 8'h00;
  localparam logic [7:0] RESET_CMD_DEFAULT = 8'hf0;
  localparam logic [7:0] ID_CMD_DEFAULT = 8'h90;
  localparam logic [20:0] UNLOCK1_ADDR_DEFAULT = 21'h000555;
  localparam logic [7:0] UNLOCK1_DATA_DEFAULT = 8'haa;
  localparam logic [20:0] UNLOCK2_ADDR_DEFAULT = 21'h0002aa;
  localparam logic [7:0] UNLOCK2_DATA_DEFAULT = 8'h55;
  localparam int CLK_PERIOD_NS = 50;
  localparam int SETUP_NS = 100;
  localparam int PULSE_NS = 100;
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_CYC = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] SETUP_CNT = 4'(SETUP_CYC);
  localparam logic [3:0] PULSE_CNT = 4'(PULSE_CYC);
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam int SYNC_CYC = 3;
  localparam logic [3:0] READ_PULSE_CNT = 4'(PULSE_CYC + SYNC_CYC);
  localparam int TLE_BIT = 5;

  typedef enum logic [1:0] {
    FCWC_OP_WRITE,
    FCWC_OP_READ,
    FCWC_OP_RESET,
    FCWC_OP_IDENT
  } fcwc_op_type;

  typedef struct packed {
    fcwc_op_type op;
    logic [20:0] addr;
    logic [7:0] data;
  } fcwc_req_type;

  typedef struct packed {
    logic chip_en_n;
    logic write_en_n;
    logic out_en_n;
  } fcwc_strobe_type;
endpackage : fcwc_pkg

/* File: rtl/fcwc_sync.sv */
// Three-stage input synchroniser for pins arriving from the flash device.
// Assumes one clock; the change is taken once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module fcwc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] held;
  logic [WIDTH-1:0] next_held;

  always_comb
  begin
    next_held = held;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (stage2[i] == stage3[i])
      begin
        next_held[i] = stage3[i];
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      held <= '0;
    end
    else if (clk_en_i)
    begin
      stage1 <= async_i;
      stage2 <= stage1;
      stage3 <= stage2;
      held <= next_held;
    end
  end

  assign sync_o = held;
endmodule : fcwc_sync
`default_nettype wire

/* File: tb/fcwc_flash_model.sv */
// Behavioural flash device facing the host controller.
// Assumes active-low strobes and a bus resolved by the bench.
`timescale 1ns/1ps
`default_nettype none
module fcwc_flash_model
  import fcwc_pkg::*;
#(
  parameter logic [7:0] MFR = 8'h3c, // Arbitrary value.
  parameter logic [7:0] DEV = 8'hc3, // Arbitrary value.
  parameter logic [7:0] PMASK = 8'ha5,
  parameter int HOLD_NS = 400
) (
  input wire fcwc_strobe_type strobe_i,
  input wire logic [20:0] addr_i,
  input wire logic [7:0] data_i,
  input wire logic hv_i,
  output var logic [7:0] data_o,
  output var int bad_o
);
  typedef enum logic [1:0] {FCWC_ARR, FCWC_U1, FCWC_U2, FCWC_ID} fcwc_mode_type;
  fcwc_mode_type mode;
  logic [20:0] lat;
  logic [7:0] held;
  logic armed;
  wire logic wr_n = strobe_i.chip_en_n | strobe_i.write_en_n;
  wire logic rd_n = strobe_i.chip_en_n | strobe_i.out_en_n;
  function automatic logic [7:0] rd_byte(input logic [20:0] a);
    if (mode != FCWC_ID)
      return a[7:0] ^ a[15:8] ^ {3'h0, a[20:16]};
    if (a[7:0] == ID_MFR_LOW)
      return MFR;
    if (a[7:0] == ID_DEV_LOW)
      return DEV;
    return (PMASK[a[GROUP_MSB:GROUP_LSB]] && !hv_i) ? PROT_YES : PROT_NO;
  endfunction : rd_byte
  initial
  begin
    mode = FCWC_ARR;
    bad_o = 0;
    data_o = 8'hff;
    #1;
    armed = !(!wr_n && strobe_i.out_en_n);
  end
  always @(negedge wr_n)
    lat = addr_i;
  always @(posedge wr_n)
  begin
    if (!strobe_i.out_en_n)
      bad_o++;
    else if (!armed)
      armed = 1'b1;
    else if (data_i == RESET_CMD_DEFAULT)
      mode = FCWC_ARR;
    else if (mode == FCWC_ID)
      mode = FCWC_ID;
    else if (mode == FCWC_ARR && lat == UNLOCK1_ADDR_DEFAULT && data_i == UNLOCK1_DATA_DEFAULT)
      mode = FCWC_U1;
    else if (mode == FCWC_U1 && lat == UNLOCK2_ADDR_DEFAULT && data_i == UNLOCK2_DATA_DEFAULT)
      mode = FCWC_U2;
    else if (mode == FCWC_U2 && data_i == ID_CMD_DEFAULT)
      mode = FCWC_ID;
    else
      mode = FCWC_ARR;
  end
  always @(negedge rd_n)
  begin
    held = rd_byte(addr_i);
    data_o = held;
  end
  // The byte is held a while after release, then the bus shows garbage.
  always @(posedge rd_n)
  begin
    #(HOLD_NS);
    if (rd_n)
      data_o = ~held;
  end
endmodule : fcwc_flash_model
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the flash host controller.
// Assumes the behavioural flash model on the far side of the pins.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import fcwc_pkg::*;
;
  localparam logic [7:0] PMASK = 8'ha5;
  logic ref_clk_i = 1'b0;
  logic rst_i, req_valid_i, unprotect_req_i;
  logic clk_en, timeout_seen_o;
  logic [7:0] exp_b;
  fcwc_req_type req_i;
  logic req_ready_o, rd_valid_o, ident_mode_o, hv_reset_en_o, data_oe_o;
  logic [7:0] rd_data_o, data_o, dev_data, bus;
  logic [20:0] addr_o, a;
  fcwc_strobe_type strobe_o;
  int bad_cnt;
  int miscompares = 0;
  int check_count = 0;
  logic [31:0] seed = 32'h6290;
  assign bus = data_oe_o ? data_o : dev_data;
  fcwc_host i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .clk_en_i(clk_en), .req_i(req_i),
    .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o), .ident_mode_o(ident_mode_o), .timeout_seen_o(timeout_seen_o),
    .unprotect_req_i(unprotect_req_i), .hv_reset_en_o(hv_reset_en_o), .strobe_o(strobe_o),
    .addr_o(addr_o), .data_o(data_o), .data_oe_o(data_oe_o), .data_i(bus));
  fcwc_flash_model #(.PMASK(PMASK)) i_flash (.strobe_i(strobe_o), .addr_i(addr_o),
    .data_i(bus), .hv_i(hv_reset_en_o), .data_o(dev_data), .bad_o(bad_cnt));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  function automatic logic [7:0] arr(input logic [20:0] x);
    return x[7:0] ^ x[15:8] ^ {3'h0, x[20:16]};
  endfunction : arr
  task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic issue(input fcwc_op_type op, input logic [20:0] ad, input logic [7:0] d);
    int n;
    @(negedge ref_clk_i);
    req_i = '{op: op, addr: ad, data: d};
    req_valid_i = 1'b1;
    n = 0;
    while (req_ready_o !== 1'b1 && n < 200)
    begin
      @(negedge ref_clk_i);
      n++;
    end
    @(negedge ref_clk_i);
    req_valid_i = 1'b0;
  endtask : issue
  task automatic rd(input string what, input logic [20:0] ad, input logic [7:0] exp);
    int n;
    issue(FCWC_OP_READ, ad, 8'h00);
    n = 0;
    while (rd_valid_o !== 1'b1 && n < 50)
    begin
      @(negedge ref_clk_i);
      n++;
    end
    check(what, {1'b1, exp}, {rd_valid_o, rd_data_o});
  endtask : rd
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out
  initial
  begin
    forever
      #25 ref_clk_i = ~ref_clk_i;
  end
  initial
  begin
    #(50 * 30000);
    miscompares++;
    $display("watchdog expired");
    close_out();
  end
  initial
  begin
    rst_i = 1'b1;
    clk_en = 1'b1;
    req_valid_i = 1'b0;
    unprotect_req_i = 1'b0;
    req_i = '0;
    repeat (10) @(negedge ref_clk_i);
    rst_i = 1'b0;
    for (int i = 0; i < 6; i++)
    begin
      seed = xs(seed);
      a = seed[20:0];
      rd("array", a, arr(a));
    end
    $display("test power_up_read done");
    @(negedge ref_clk_i);
    clk_en = 1'b0;
    req_i = '{op: FCWC_OP_READ, addr: a, data: 8'h00};
    req_valid_i = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    check("freeze", 9'h007, {6'h0, strobe_o});
    req_valid_i = 1'b0;
    @(negedge ref_clk_i);
    clk_en = 1'b1;
    rd("thaw", a, arr(a));
    $display("test freeze done");
    issue(FCWC_OP_IDENT, 21'h0, 8'h00);
    for (int g = 0; g < 8; g++)
    begin
      seed = xs(seed);
      rd("maker", {seed[20:8], ID_MFR_LOW}, 8'h3c);
      rd("device", {seed[20:8], ID_DEV_LOW}, 8'hc3);
      rd("prot", {g[2:0], seed[17:8], ID_PROT_LOW}, PMASK[g] ? PROT_YES : PROT_NO);
    end
    check("ident", 9'h1, {8'h0, ident_mode_o});
    issue(FCWC_OP_WRITE, UNLOCK1_ADDR_DEFAULT, UNLOCK1_DATA_DEFAULT);
    rd("stay", {13'h0, ID_MFR_LOW}, 8'h3c);
    $display("test ident done");
    @(negedge ref_clk_i);
    unprotect_req_i = 1'b1;
    repeat (3) @(negedge ref_clk_i);
    check("hv", 9'h1, {8'h0, hv_reset_en_o});
    rd("unprot", {13'h0, ID_PROT_LOW}, PROT_NO);
    unprotect_req_i = 1'b0;
    repeat (3) @(negedge ref_clk_i);
    rd("reprot", {13'h0, ID_PROT_LOW}, PROT_YES);
    $display("test unprotect done");
    seed = xs(seed);
    issue(FCWC_OP_RESET, seed[20:0], 8'h00);
    a = seed[20:0] ^ 21'h0a5a5;
    rd("reset", a, arr(a));
    exp_b = arr(a);
    check("timeout", {8'h0, exp_b[TLE_BIT]}, {8'h0, timeout_seen_o});
    check("ident", 9'h0, {8'h0, ident_mode_o});
    issue(FCWC_OP_WRITE, UNLOCK1_ADDR_DEFAULT, UNLOCK1_DATA_DEFAULT);
    issue(FCWC_OP_RESET, 21'h1fffff, 8'h00);
    issue(FCWC_OP_WRITE, UNLOCK2_ADDR_DEFAULT, UNLOCK2_DATA_DEFAULT);
    issue(FCWC_OP_WRITE, UNLOCK1_ADDR_DEFAULT, ID_CMD_DEFAULT);
    rd("abort", a, arr(a));
    seed = xs(seed);
    issue(FCWC_OP_WRITE, UNLOCK1_ADDR_DEFAULT, UNLOCK1_DATA_DEFAULT);
    issue(FCWC_OP_WRITE, UNLOCK2_ADDR_DEFAULT, seed[7:0] | 8'h80);
    issue(FCWC_OP_WRITE, UNLOCK1_ADDR_DEFAULT, ID_CMD_DEFAULT);
    rd("bad", a, arr(a));
    check("strobes", 9'h0, bad_cnt[8:0]);
    $display("test reset_abort done");
    close_out();
  end
endmodule : testbench
`default_nettype wire
